// ---- rtl/txm_consts.svh ----
// Purpose: Offsets, fields, reset values and timing of the link mapper
// Assumes: 50 MHz mclk_i
// Notes: Included by both ends
`ifndef TXM_CONSTS_SVH
`define TXM_CONSTS_SVH
// Register offsets
`define TXM_OFS_MODE 12'h0200
`define TXM_OFS_DCM 12'h0201
`define TXM_OFS_RATE 12'h056E
`define TXM_OFS_PLL 12'h056F
`define TXM_OFS_QCFG 12'h0570
`define TXM_OFS_CTRL 12'h0571
// Field positions
`define TXM_MODE_Q_IGN 5
`define TXM_PLL_LOCK_BIT 7
`define TXM_PLL_MISMATCH_BIT 0
`define TXM_CTRL_PDN_BIT 0
// Reset values
`define TXM_RST_MODE 8'h00
`define TXM_RST_DCM 8'h01
`define TXM_RST_RATE 8'h00
`define TXM_RST_QCFG 8'h49
`define TXM_RST_CTRL 8'h00
// Lane-rate field codes and thresholds in half-Mbps units
`define TXM_RATE_HI 4'h3
`define TXM_RATE_MID 4'h0
`define TXM_RATE_LOW 4'h1
`define TXM_RATE_VLOW 4'h5
`define TXM_HMBPS_MIN 32'd3375
`define TXM_HMBPS_3G375 32'd6750
`define TXM_HMBPS_6G75 32'd13500
`define TXM_HMBPS_13G5 32'd27000
`define TXM_HMBPS_MAX 32'd30000
// Serializer PLL lock time
`define TXM_CLK_NS 20
`define TXM_PLL_LOCK_NS 1000
`define TXM_PLL_LOCK_CYC ((`TXM_PLL_LOCK_NS + `TXM_CLK_NS - 1) / `TXM_CLK_NS)
// Host poll limit before giving up on lock
`define TXM_POLL_MAX 8'hFF
`endif

// ---- rtl/txm_pkg.sv ----
// Purpose: Types and shared decoders of the link mapper
// Assumes: 16-bit sample words
// Notes: Numbers live in txm_consts.svh
package txm_pkg;
  typedef logic [3:0][15:0] txm_vc_t;
  typedef struct packed {
    logic ok;
    logic [1:0] l;
    logic [2:0] m;
    logic [3:0] f;
  } txm_lmf_t;
  typedef enum logic [3:0] {
    TXM_FULL_BW = 4'h0,
    TXM_ONE_DDC = 4'h1,
    TXM_TWO_DDC = 4'h2
  } txm_mode_t;

  // quick code table, 16-bit samples only
  function automatic txm_lmf_t txm_qcfg_decode(input logic [7:0] code);
    txm_lmf_t r;
    r = '0;
    unique case (code)
      8'h01: r = '{1'b1, 2'd1, 3'd1, 4'd2};
      8'h40: r = '{1'b1, 2'd2, 3'd1, 4'd1};
      8'h41: r = '{1'b1, 2'd2, 3'd1, 4'd2};
      8'h0A: r = '{1'b1, 2'd1, 3'd2, 4'd4};
      8'h49: r = '{1'b1, 2'd2, 3'd2, 4'd2};
      8'h13: r = '{1'b1, 2'd1, 3'd4, 4'd8};
      8'h52: r = '{1'b1, 2'd2, 3'd4, 4'd4};
      default: r = '0;
    endcase
    return r;
  endfunction
endpackage

// ---- rtl/txm_if.sv ----
// Purpose: Joins the transmit mapper and its configuring receiver
// Assumes: One clock for both ends
// Notes: Register port plus per-link virtual converter frames
`timescale 1ns/100ps
`default_nettype none
interface txm_if
  import txm_pkg::*;
();
  logic cfg_wr;
  logic cfg_rd;
  logic [11:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  txm_vc_t link_ab_vc;
  txm_vc_t link_cd_vc;
  logic frame_vld;
  logic [1:0] lane_cnt;
  logic [2:0] conv_cnt;
  logic [3:0] octet_cnt;
  modport dev (
    input cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
    output cfg_rdata, cfg_rvalid, link_ab_vc, link_cd_vc, frame_vld,
    output lane_cnt, conv_cnt, octet_cnt
  );
  modport host (
    output cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
    input cfg_rdata, cfg_rvalid, link_ab_vc, link_cd_vc, frame_vld,
    input lane_cnt, conv_cnt, octet_cnt
  );
endinterface
`default_nettype wire

// ---- rtl/txm_dev.sv ----
// Purpose: Transmit end: serializer PLL model, registers, converter mapping
// Assumes: Samples arrive on mclk_i; both links share one configuration
// Notes: Frames carry four 16-bit virtual converter words per link
`include "txm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module txm_dev
  import txm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Link to the receiver side
  txm_if.dev lnk,
  // Physical converter samples
  input wire logic [15:0] adc_a_i,
  input wire logic [15:0] adc_b_i,
  input wire logic [15:0] adc_c_i,
  input wire logic [15:0] adc_d_i,
  // Downconverter outputs, 0-1 feed AB, 2-3 feed CD
  input wire logic [3:0][15:0] ddc_i_i,
  input wire logic [3:0][15:0] ddc_q_i,
  input wire logic sample_valid_i,
  // Status
  output logic pll_locked_o,
  output logic link_up_o
);

  ////////////////////////////////////////////////////////////////////
  // Types and helpers
  typedef enum logic [2:0] {
    PLL_DOWN = 3'b001,
    PLL_ACQ = 3'b010,
    PLL_LOCK = 3'b100
  } txm_pll_t;
  localparam int LOCK_CYC = `TXM_PLL_LOCK_CYC;
  // Virtual converters needed by mode; zero marks an illegal mode
  function automatic logic [2:0] vc_need(input logic [3:0] mode, input logic qign);
    unique case (mode)
      TXM_FULL_BW: return 3'd2;
      TXM_ONE_DDC: return qign ? 3'd1 : 3'd2;
      TXM_TWO_DDC: return qign ? 3'd2 : 3'd4;
      default: return 3'd0;
    endcase
  endfunction
  // Maps one link's streams onto virtual converters 0..3
  function automatic txm_vc_t vc_map(
    input logic [3:0] mode, input logic qign,
    input logic [15:0] cnv0, cnv1, d0i, d0q, d1i, d1q
  );
    txm_vc_t v;
    v = '0;
    if (mode == TXM_FULL_BW) begin
      v[0] = cnv0;
      v[1] = cnv1;
    end else if (mode == TXM_ONE_DDC) begin
      v[0] = d0i;
      v[1] = qign ? 16'h0000 : d0q;
    end else if (mode == TXM_TWO_DDC) begin
      v[0] = d0i;
      v[1] = qign ? d1i : d0q;
      v[2] = qign ? 16'h0000 : d1i;
      v[3] = qign ? 16'h0000 : d1q;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] dcm_r, dcm_nxt;
  logic [7:0] rate_r, rate_nxt;
  logic [7:0] qcfg_r, qcfg_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic reconf, rate_legal, mismatch;
  txm_lmf_t lmf;
  txm_pll_t pll_r, pll_nxt;
  logic [7:0] lock_cnt_r, lock_cnt_nxt;

  assign lmf = txm_qcfg_decode(qcfg_r);
  assign mismatch = !lmf.ok || (vc_need(mode_r[3:0], mode_r[`TXM_MODE_Q_IGN]) != lmf.m);
  assign rate_legal = (rate_r[7:4] == `TXM_RATE_HI) || (rate_r[7:4] == `TXM_RATE_MID) ||
                      (rate_r[7:4] == `TXM_RATE_LOW) || (rate_r[7:4] == `TXM_RATE_VLOW);
  // A write to rate or quick code retunes the serializer
  assign reconf = lnk.cfg_wr &&
                  ((lnk.cfg_addr == `TXM_OFS_RATE) || (lnk.cfg_addr == `TXM_OFS_QCFG));
  // Register writes and reads; status is not writable
  always_comb begin
    mode_nxt = mode_r;
    dcm_nxt = dcm_r;
    rate_nxt = rate_r;
    qcfg_nxt = qcfg_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = lnk.cfg_rd;
    if (lnk.cfg_wr) begin
      unique case (lnk.cfg_addr)
        `TXM_OFS_MODE: mode_nxt = lnk.cfg_wdata;
        `TXM_OFS_DCM: dcm_nxt = lnk.cfg_wdata;
        `TXM_OFS_RATE: rate_nxt = lnk.cfg_wdata;
        `TXM_OFS_QCFG: qcfg_nxt = lnk.cfg_wdata;
        `TXM_OFS_CTRL: ctrl_nxt = lnk.cfg_wdata;
        default: ;
      endcase
    end
    if (lnk.cfg_rd) begin
      unique case (lnk.cfg_addr)
        `TXM_OFS_MODE: rdata_nxt = mode_r;
        `TXM_OFS_DCM: rdata_nxt = dcm_r;
        `TXM_OFS_RATE: rdata_nxt = rate_r;
        `TXM_OFS_PLL: rdata_nxt = (8'(pll_r == PLL_LOCK) << `TXM_PLL_LOCK_BIT) |
                                  (8'(mismatch) << `TXM_PLL_MISMATCH_BIT);
        `TXM_OFS_QCFG: rdata_nxt = qcfg_r;
        `TXM_OFS_CTRL: rdata_nxt = ctrl_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r <= `TXM_RST_MODE;
      dcm_r <= `TXM_RST_DCM;
      rate_r <= `TXM_RST_RATE;
      qcfg_r <= `TXM_RST_QCFG;
      ctrl_r <= `TXM_RST_CTRL;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      dcm_r <= dcm_nxt;
      rate_r <= rate_nxt;
      qcfg_r <= qcfg_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serializer PLL model
  // lock needs a legal rate band
  always_comb begin
    pll_nxt = pll_r;
    lock_cnt_nxt = lock_cnt_r;
    unique case (pll_r)
      PLL_DOWN: begin
        lock_cnt_nxt = 8'h00;
        if (!ctrl_r[`TXM_CTRL_PDN_BIT] && rate_legal) begin
          pll_nxt = PLL_ACQ;
        end
      end
      PLL_ACQ: begin
        lock_cnt_nxt = lock_cnt_r + 8'h01;
        if (lock_cnt_r == 8'(LOCK_CYC - 1)) begin
          pll_nxt = PLL_LOCK;
        end
      end
      PLL_LOCK: lock_cnt_nxt = 8'h00;
      default: pll_nxt = PLL_DOWN;
    endcase
    // Retune wins over progress so a stale lock never shows
    if (ctrl_r[`TXM_CTRL_PDN_BIT] || !rate_legal || reconf) begin
      pll_nxt = PLL_DOWN;
      lock_cnt_nxt = 8'h00;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pll_r <= PLL_DOWN;
      lock_cnt_r <= 8'h00;
    end else begin
      pll_r <= pll_nxt;
      lock_cnt_r <= lock_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame mapping for both links
  txm_vc_t ab_r, ab_nxt;
  txm_vc_t cd_r, cd_nxt;
  logic frame_r, frame_nxt, up_r, up_nxt, lock_r, lock_nxt;
  logic [1:0] l_r, l_nxt;
  logic [2:0] m_r, m_nxt;
  logic [3:0] f_r, f_nxt;
  always_comb begin
    lock_nxt = (pll_r == PLL_LOCK);
    up_nxt = lock_nxt && !mismatch;
    l_nxt = lmf.l;
    m_nxt = lmf.m;
    f_nxt = lmf.f;
    ab_nxt = ab_r;
    cd_nxt = cd_r;
    frame_nxt = 1'b0;
    if (up_r && sample_valid_i) begin
      ab_nxt = vc_map(mode_r[3:0], mode_r[`TXM_MODE_Q_IGN], adc_a_i, adc_b_i,
                      ddc_i_i[0], ddc_q_i[0], ddc_i_i[1], ddc_q_i[1]);
      cd_nxt = vc_map(mode_r[3:0], mode_r[`TXM_MODE_Q_IGN], adc_c_i, adc_d_i,
                      ddc_i_i[2], ddc_q_i[2], ddc_i_i[3], ddc_q_i[3]);
      frame_nxt = 1'b1;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ab_r <= '0;
      cd_r <= '0;
      frame_r <= 1'b0;
      up_r <= 1'b0;
      lock_r <= 1'b0;
      l_r <= 2'd0;
      m_r <= 3'd0;
      f_r <= 4'd0;
    end else begin
      ab_r <= ab_nxt;
      cd_r <= cd_nxt;
      frame_r <= frame_nxt;
      up_r <= up_nxt;
      lock_r <= lock_nxt;
      l_r <= l_nxt;
      m_r <= m_nxt;
      f_r <= f_nxt;
    end
  end
  // Outputs straight from flip-flops
  assign lnk.cfg_rdata = rdata_r;
  assign lnk.cfg_rvalid = rvalid_r;
  assign lnk.link_ab_vc = ab_r;
  assign lnk.link_cd_vc = cd_r;
  assign lnk.frame_vld = frame_r;
  assign lnk.lane_cnt = l_r;
  assign lnk.conv_cnt = m_r;
  assign lnk.octet_cnt = f_r;
  assign pll_locked_o = lock_r;
  assign link_up_o = up_r;

endmodule
`default_nettype wire

// ---- rtl/txm_host.sv ----
// Purpose: Configuring receiver end: checks rate, programs link, waits lock
// Assumes: Converter clock given in whole MHz
// Notes: Passes received frames through one register stage
`include "txm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module txm_host
  import txm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Link to the transmit end
  txm_if.host lnk,
  // Setup request
  input wire logic start_i,
  input wire logic [3:0] mode_i,
  input wire logic q_ignore_i,
  input wire logic [7:0] qcfg_i,
  input wire logic [7:0] dcm_i,
  input wire logic [10:0] fadc_mhz_i,
  // Setup result
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic [3:0] rate_field_o,
  // Received frames
  output txm_vc_t rx_ab_vc_o,
  output txm_vc_t rx_cd_vc_o,
  output logic rx_vld_o
);

  typedef enum logic [8:0] {
    H_IDLE = 9'b000000001,
    H_PDN = 9'b000000010,
    H_QCFG = 9'b000000100,
    H_MODE = 9'b000001000,
    H_DCM = 9'b000010000,
    H_RATE = 9'b000100000,
    H_PUP = 9'b001000000,
    H_POLL = 9'b010000000,
    H_WAIT = 9'b100000000
  } txm_hst_t;

  ////////////////////////////////////////////////////////////////////
  // Lane rate check, half-Mbps units

  txm_lmf_t lmf;
  logic [31:0] num2;
  logic [31:0] den;
  logic range_ok;
  logic [3:0] field;

  assign lmf = txm_qcfg_decode(qcfg_i);
  // 2 x M x 16 x 10/8 x fadc / dcm / L, in half-Mbps
  assign num2 = 32'(lmf.m) * 32'd40 * 32'(fadc_mhz_i);
  assign den = 32'(dcm_i) * 32'(lmf.l);
  assign range_ok = lmf.ok && (dcm_i != 8'h00) &&
                    (num2 >= `TXM_HMBPS_MIN * den) && (num2 <= `TXM_HMBPS_MAX * den);

  always_comb begin
    if (num2 > `TXM_HMBPS_13G5 * den) begin
      field = `TXM_RATE_HI;
    end else if (num2 > `TXM_HMBPS_6G75 * den) begin
      field = `TXM_RATE_MID;
    end else if (num2 > `TXM_HMBPS_3G375 * den) begin
      field = `TXM_RATE_LOW;
    end else begin
      field = `TXM_RATE_VLOW;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  txm_hst_t st_r, st_nxt;
  logic [7:0] qcfg_r, qcfg_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] dcm_r, dcm_nxt;
  logic [3:0] fld_r, fld_nxt;
  logic [7:0] poll_r, poll_nxt;
  logic wr_r, wr_nxt;
  logic rd_r, rd_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic done_r, done_nxt;
  logic err_r, err_nxt;
  logic busy_r, busy_nxt;

  always_comb begin
    st_nxt = st_r;
    qcfg_nxt = qcfg_r;
    mode_nxt = mode_r;
    dcm_nxt = dcm_r;
    fld_nxt = fld_r;
    poll_nxt = poll_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    done_nxt = 1'b0;
    err_nxt = err_r;
    unique case (st_r)
      H_IDLE: if (start_i) begin
        err_nxt = !range_ok;
        qcfg_nxt = qcfg_i;
        mode_nxt = {2'b00, q_ignore_i, 1'b0, mode_i};
        dcm_nxt = dcm_i;
        fld_nxt = field;
        poll_nxt = 8'h00;
        if (range_ok) begin
          st_nxt = H_PDN;
          wr_nxt = 1'b1;
          addr_nxt = `TXM_OFS_CTRL;
          wdata_nxt = 8'h01;
        end
      end
      H_PDN: begin
        st_nxt = H_QCFG;
        wr_nxt = 1'b1;
        addr_nxt = `TXM_OFS_QCFG;
        wdata_nxt = qcfg_r;
      end
      H_QCFG: begin
        st_nxt = H_MODE;
        wr_nxt = 1'b1;
        addr_nxt = `TXM_OFS_MODE;
        wdata_nxt = mode_r;
      end
      H_MODE: begin
        st_nxt = H_DCM;
        wr_nxt = 1'b1;
        addr_nxt = `TXM_OFS_DCM;
        wdata_nxt = dcm_r;
      end
      H_DCM: begin
        st_nxt = H_RATE;
        wr_nxt = 1'b1;
        addr_nxt = `TXM_OFS_RATE;
        wdata_nxt = {fld_r, 4'h0};
      end
      H_RATE: begin
        st_nxt = H_PUP;
        wr_nxt = 1'b1;
        addr_nxt = `TXM_OFS_CTRL;
        wdata_nxt = 8'h00;
      end
      H_PUP, H_POLL: begin
        st_nxt = H_WAIT;
        rd_nxt = 1'b1;
        addr_nxt = `TXM_OFS_PLL;
      end
      H_WAIT: if (lnk.cfg_rvalid) begin
        poll_nxt = poll_r + 8'h01;
        if (lnk.cfg_rdata[`TXM_PLL_LOCK_BIT]) begin
          st_nxt = H_IDLE;
          done_nxt = 1'b1;
        end else if (poll_r == `TXM_POLL_MAX) begin
          st_nxt = H_IDLE;
          err_nxt = 1'b1;
        end else begin
          st_nxt = H_POLL;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
    busy_nxt = (st_nxt != H_IDLE); // Busy from a flop, in step with the state
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= H_IDLE;
      qcfg_r <= 8'h00;
      mode_r <= 8'h00;
      dcm_r <= 8'h00;
      fld_r <= 4'h0;
      poll_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= 12'h000;
      wdata_r <= 8'h00;
      done_r <= 1'b0;
      err_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      qcfg_r <= qcfg_nxt;
      mode_r <= mode_nxt;
      dcm_r <= dcm_nxt;
      fld_r <= fld_nxt;
      poll_r <= poll_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      busy_r <= busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame capture, one stage so outputs stay registered

  txm_vc_t ab_r, cd_r;
  logic vld_r;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ab_r <= '0;
      cd_r <= '0;
      vld_r <= 1'b0;
    end else begin
      ab_r <= lnk.frame_vld ? lnk.link_ab_vc : ab_r;
      cd_r <= lnk.frame_vld ? lnk.link_cd_vc : cd_r;
      vld_r <= lnk.frame_vld;
    end
  end

  assign lnk.cfg_wr = wr_r;
  assign lnk.cfg_rd = rd_r;
  assign lnk.cfg_addr = addr_r;
  assign lnk.cfg_wdata = wdata_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign err_o = err_r;
  assign rate_field_o = fld_r;
  assign rx_ab_vc_o = ab_r;
  assign rx_cd_vc_o = cd_r;
  assign rx_vld_o = vld_r;

endmodule
`default_nettype wire

// ---- sim/txm_assertions.sv ----
// Purpose: Concurrent checks on the link between transmit mapper and receiver
// Assumes: One clock, interface signals only
// Notes: Instantiated by tb beside the interface
`include "txm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module txm_assertions
  import txm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  // Frames and link parameters
  input wire txm_vc_t link_ab_vc,
  input wire txm_vc_t link_cd_vc,
  input wire logic frame_vld,
  input wire logic [1:0] lane_cnt,
  input wire logic [2:0] conv_cnt,
  input wire logic [3:0] octet_cnt
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////////
  // quick code decode
  a_quick_code_lmf: assert property (
    $past(cfg_wr, 2) && $past(cfg_addr, 2) == `TXM_OFS_QCFG && $past(cfg_wdata, 2) == 8'h13
    && !($past(cfg_wr) && $past(cfg_addr) == `TXM_OFS_QCFG)
    |-> lane_cnt == 2'h1 && conv_cnt == 3'h4 && octet_cnt == 4'h8)
    else $error("Quick code 13 gave wrong link parameters");
  a_config_order: assert property (
    cfg_wr && cfg_addr == `TXM_OFS_CTRL && cfg_wdata == 8'h01
    |=> cfg_wr && cfg_addr == `TXM_OFS_QCFG ##1 cfg_wr && cfg_addr == `TXM_OFS_MODE
    ##1 cfg_wr && cfg_addr == `TXM_OFS_DCM ##1 cfg_wr && cfg_addr == `TXM_OFS_RATE
    ##1 cfg_wr && cfg_addr == `TXM_OFS_CTRL && cfg_wdata == 8'h00)
    else $error("Configuration writes out of order");
  a_relock_no_frames: assert property (
    cfg_wr && (cfg_addr == `TXM_OFS_RATE || cfg_addr == `TXM_OFS_QCFG)
    |-> ##2 !frame_vld [*8])
    else $error("Frame sent while serializer relocks");
  a_rate_byte_legal: assert property (
    cfg_wr && cfg_addr == `TXM_OFS_RATE |-> cfg_wdata[3:0] == 4'h0
    && cfg_wdata[7:4] inside {4'h3, 4'h0, 4'h1, 4'h5})
    else $error("Illegal lane-rate byte written");
  a_status_read_shape: assert property (
    cfg_rd && cfg_addr == `TXM_OFS_PLL |=> cfg_rvalid && cfg_rdata[6:1] == 6'h00)
    else $error("Status read answer malformed");
  a_rdata_held: assert property (
    !cfg_rd |=> $stable(cfg_rdata) && !cfg_rvalid)
    else $error("Read data moved without a read");
  // no frames on an illegal quick code
  a_frames_need_code: assert property (
    frame_vld |-> conv_cnt != 3'h0 && lane_cnt != 2'h0)
    else $error("Frame sent with illegal link parameters");
  a_unused_upper_zero: assert property (
    frame_vld && conv_cnt != 3'h4 |-> link_ab_vc[3:2] == '0 && link_cd_vc[3:2] == '0)
    else $error("Unused virtual converter not zero");
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the mapper and its configuring receiver
// Assumes: 50 MHz clock, seed 67
// Notes: Expectations come from local tables and functions
`include "txm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb
  import txm_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] adc_a = 16'h0000;
  logic [15:0] adc_b = 16'h0000;
  logic [15:0] adc_c = 16'h0000;
  logic [15:0] adc_d = 16'h0000;
  logic [3:0][15:0] ddc_i = '0;
  logic [3:0][15:0] ddc_q = '0;
  logic sample_valid = 1'b0;
  logic start = 1'b0;
  logic [31:0] setup = '0;
  logic busy, done, err, pll_locked, link_up, rx_vld;
  logic [3:0] rate_field;
  txm_vc_t rx_ab, rx_cd;
  int fail_count = 0;
  int total_checks = 0;
  // Legal quick codes for random setups
  localparam logic [7:0] CODES [7] = '{8'h01, 8'h40, 8'h41, 8'h0A, 8'h49, 8'h13, 8'h52};
  // Corner setups: mode, q-ignore, quick code, ratio, MHz
  localparam logic [31:0] CASES [12] = '{
    {4'h0, 1'b0, 8'h49, 8'h01, 11'h1F4}, {4'h1, 1'b1, 8'h01, 8'h04, 11'h1F4},
    {4'h1, 1'b0, 8'h0A, 8'h04, 11'h190}, {4'h2, 1'b0, 8'h13, 8'h04, 11'h1F4},
    {4'h2, 1'b0, 8'h52, 8'h04, 11'h578}, {4'h1, 1'b1, 8'h40, 8'h04, 11'h2A3},
    {4'h1, 1'b1, 8'h01, 8'h01, 11'h2EE}, {4'h1, 1'b1, 8'h01, 8'h01, 11'h2EF},
    {4'h0, 1'b0, 8'h49, 8'h00, 11'h1F4}, {4'h0, 1'b0, 8'h42, 8'h01, 11'h1F4},
    {4'h0, 1'b0, 8'h13, 8'h04, 11'h1F4}, {4'h2, 1'b1, 8'h49, 8'h04, 11'h1F4}};
  ////////////////////////////////////////////////////////////////////////////////
  txm_if lnk_if ();
  txm_dev txm_dev_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .lnk(lnk_if.dev),
    .adc_a_i(adc_a), .adc_b_i(adc_b), .adc_c_i(adc_c), .adc_d_i(adc_d),
    .ddc_i_i(ddc_i), .ddc_q_i(ddc_q), .sample_valid_i(sample_valid),
    .pll_locked_o(pll_locked), .link_up_o(link_up));
  txm_host txm_host_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .lnk(lnk_if.host),
    .start_i(start), .mode_i(setup[31:28]), .q_ignore_i(setup[27]), .qcfg_i(setup[26:19]),
    .dcm_i(setup[18:11]), .fadc_mhz_i(setup[10:0]), .busy_o(busy), .done_o(done),
    .err_o(err), .rate_field_o(rate_field), .rx_ab_vc_o(rx_ab), .rx_cd_vc_o(rx_cd),
    .rx_vld_o(rx_vld));
  txm_assertions txm_assertions_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .cfg_wr(lnk_if.cfg_wr), .cfg_rd(lnk_if.cfg_rd), .cfg_addr(lnk_if.cfg_addr),
    .cfg_wdata(lnk_if.cfg_wdata), .cfg_rdata(lnk_if.cfg_rdata),
    .cfg_rvalid(lnk_if.cfg_rvalid), .link_ab_vc(lnk_if.link_ab_vc),
    .link_cd_vc(lnk_if.link_cd_vc), .frame_vld(lnk_if.frame_vld),
    .lane_cnt(lnk_if.lane_cnt), .conv_cnt(lnk_if.conv_cnt), .octet_cnt(lnk_if.octet_cnt));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  always #10 mclk_i = ~mclk_i;
  // Expected L, M, F, zero for codes outside the 16-bit set
  function automatic logic [8:0] lmf(input logic [7:0] c);
    case (c)
      8'h01: return {2'h1, 3'h1, 4'h2};
      8'h40: return {2'h2, 3'h1, 4'h1};
      8'h41: return {2'h2, 3'h1, 4'h2};
      8'h0A: return {2'h1, 3'h2, 4'h4};
      8'h49: return {2'h2, 3'h2, 4'h2};
      8'h13: return {2'h1, 3'h4, 4'h8};
      8'h52: return {2'h2, 3'h4, 4'h4};
      default: return 9'h000;
    endcase
  endfunction
  // Converters a mode needs; mismatch stops frames
  function automatic logic [2:0] need_m(input logic [3:0] md, input logic qi);
    if (md == 4'h0) return 3'h2;
    if (md == 4'h1) return qi ? 3'h1 : 3'h2;
    return qi ? 3'h2 : 3'h4;
  endfunction
  // Refusal flag and rate field, in half-Mbps to stay integer
  function automatic logic [4:0] exp_rate(input logic [7:0] c, input logic [7:0] d,
      input logic [10:0] f);
    logic [8:0] p;
    longint r;
    longint lim;
    p = lmf(c);
    r = longint'(p[6:4]) * 40 * f;
    lim = longint'(d) * p[8:7];
    if (lim == 0 || r < `TXM_HMBPS_MIN * lim || r > `TXM_HMBPS_MAX * lim) return 5'h10;
    if (r > `TXM_HMBPS_13G5 * lim) return 5'h03;
    if (r > `TXM_HMBPS_6G75 * lim) return 5'h00;
    if (r > `TXM_HMBPS_3G375 * lim) return 5'h01;
    return 5'h05;
  endfunction
  // Expected virtual converter words of one link
  function automatic txm_vc_t exp_vc(input logic [3:0] md, input logic qi,
      input logic [15:0] c0, c1, i0, q0, i1, q1);
    if (md == 4'h0) return {32'h0000_0000, c1, c0};
    if (md == 4'h1) return {32'h0000_0000, qi ? 16'h0000 : q0, i0};
    return qi ? {32'h0000_0000, i1, i0} : {q1, i1, q0, i0};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One sample beat, then the frame as seen by the receiver
  task automatic chk_frame(input logic [3:0] md, input logic qi, input logic up);
    txm_vc_t eab, ecd;
    int n;
    @(posedge mclk_i);
    #1;
    adc_a = 16'($urandom);
    adc_b = 16'($urandom);
    adc_c = 16'($urandom);
    adc_d = 16'($urandom);
    ddc_i = {$urandom, $urandom};
    ddc_q = {$urandom, $urandom};
    sample_valid = 1'b1;
    eab = exp_vc(md, qi, adc_a, adc_b, ddc_i[0], ddc_q[0], ddc_i[1], ddc_q[1]);
    ecd = exp_vc(md, qi, adc_c, adc_d, ddc_i[2], ddc_q[2], ddc_i[3], ddc_q[3]);
    @(posedge mclk_i);
    #1;
    sample_valid = 1'b0;
    n = 0;
    while (rx_vld !== 1'b1 && n < 4) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    check(rx_vld, up);
    if (up) begin
      check(rx_ab, eab);
      check(rx_cd, ecd);
    end
  endtask
  // Full setup through the receiver, then a frame
  task automatic run_cfg(input logic [31:0] cs);
    logic [4:0] e;
    logic [8:0] p;
    logic up;
    int n;
    p = lmf(cs[26:19]);
    e = exp_rate(cs[26:19], cs[18:11], cs[10:0]);
    up = (p[6:4] == need_m(cs[31:28], cs[27]));
    @(posedge mclk_i);
    #1;
    setup = cs;
    start = 1'b1;
    @(posedge mclk_i);
    #1;
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && err !== 1'b1 && n < 3000) begin
      if (n == 4) check(pll_locked, 1'b0);
      if (n == 4) check(busy, 1'b1);
      @(posedge mclk_i);
      #1;
      n++;
    end
    check(done | err, 1'b1);
    check(busy, 1'b0);
    check(err, e[4]);
    if (e[4] === 1'b0) begin
      check(rate_field, e[3:0]);
      check(pll_locked, 1'b1);
      check({lnk_if.lane_cnt, lnk_if.conv_cnt, lnk_if.octet_cnt}, p);
      repeat (2) @(posedge mclk_i);
      #1;
      check(link_up, up);
      chk_frame(cs[31:28], cs[27], up);
    end
    $display("test setup %h ends", cs);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond twenty setups of about a hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    void'($urandom(67));
    repeat (20) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    // Reset values lock by themselves in full bandwidth
    repeat (60) @(posedge mclk_i);
    #1;
    check(pll_locked, 1'b1);
    check({lnk_if.lane_cnt, lnk_if.conv_cnt, lnk_if.octet_cnt}, 9'h122);
    chk_frame(4'h0, 1'b0, 1'b1);
    $display("test reset defaults ends");
    for (int k = 0; k < 12; k++) begin
      run_cfg(CASES[k]);
    end
    for (int k = 0; k < 8; k++) begin
      run_cfg({4'($urandom % 3), 1'($urandom), CODES[$urandom % 7],
        8'(1 + $urandom % 16), 11'(100 + $urandom % 1400)});
    end
    finish_test();
  end
endmodule
`default_nettype wire
